// >>> logic/legacy_display_compat_regs.v
// Legacy display compatibility register bank reached by host I/O port cycles
//
// How it works
// - Upper-page bit clear maps out host access to the B800:0H page.
// - Graphics-enable bit permits graphics; mode register override at 3B8 gates it.
// - Blink bit enables character blinking when set, disabled when clear.
// - Black-and-white graphics bit selects 640 by 200 two-colour graphics.
// - Video-enable bit clear deactivates video; host clears it during mode changes.
// - Text/graphics bit selects alpha at 0, 320 by 200 graphics at 1.
// - Lowest operation bit selects 40x25 text at 0, 80x25 at 1.
// - Colour-set bit picks green/red/brown or cyan/magenta/white palette.
// - Alternate-set bit: alpha background at 0, alternate graphics set at 1.
// - Intensity bit intensifies border/background, or gives intensified foreground at 640.
// - Green and blue bits add colour to border, background or foreground.
// - Mono status top bit reads 0 during vertical retrace, else 1.
// - Mono status video bit reads 1 when monochrome video is enabled.
// - Both status registers read lowest bit 0 during active display.
// - Colour status retrace bit reads 1 during vertical retrace.
// - Colour status switch bit reads 0 closed, 1 open.
// - Colour status latch bit reads 1 while light-pen latch is set.
// - Extended 400-line mode register clears all bits on reset.
// - Extended register responds only when video_select_register bit 7 is set.
// - Underline bit: blue foreground at 0, white underlined at 1.
// - Page-select bit starts 200-line display page at B800:0H or BC00:0H.
// - Character-set bit takes font from plane 2 or plane 3.
// - All compatibility registers accept port cycles only when video_select_register bit 6 is set; colour-select and extended outputs ignore it.
// - Lowest extended bit selects 200-line paired or 400-line graphics.
`timescale 1ns/100ps
`include "legacy_display_compat_defines.vh"

module legacy_display_compat_regs
#(
    parameter ADDR_WIDTH = 10
)
(
    input wire i_mclk,
    input wire i_srst,
    input wire [ADDR_WIDTH-1:0] i_io_addr,
    input wire i_io_wr,
    input wire i_io_rd,
    input wire [7:0] i_io_wdata,
    output reg [7:0] o_io_rdata,
    output wire o_io_rd_hit,
    input wire i_compat_mode,
    input wire i_ext_mode_enable,
    input wire i_mode_override,
    input wire i_vsync,
    input wire i_display_enable,
    input wire i_mono_video_on,
    input wire i_pen_switch_closed,
    input wire i_pen_latch_set,
    output reg o_upper_page_access,
    output reg o_graphics_enable,
    output reg o_blink_enable,
    output reg o_bw_graphics_640,
    output reg o_video_enable,
    output reg o_graphics_320,
    output reg o_text_80_columns,
    output reg o_color_set_cyan,
    output reg o_alt_color_set,
    output reg o_intensity,
    output reg [2:0] o_border_rgb,
    output reg [3:0] o_background_irgb,
    output reg [3:0] o_foreground_irgb,
    output reg o_underline_white,
    output reg o_page_bc00,
    output reg o_font_plane3,
    output reg o_lines_400
);

////////////////////////////////////////////////////////////////////////////////
// Decode

function hit;
    input [ADDR_WIDTH-1:0] addr;
    input [9:0] port;
    begin
        hit = (addr == port[ADDR_WIDTH-1:0]);
    end
endfunction

reg [7:0] mono_graphics_page_ctrl;
reg [7:0] color_graphics_operation;
reg [7:0] color_graphics_color_select;
reg [7:0] extended_400_line_mode;

wire wr_mgp = i_io_wr && i_compat_mode && hit(i_io_addr, `PORT_MONO_GRAPHICS_PAGE_CTRL);
wire wr_cgo = i_io_wr && i_compat_mode && hit(i_io_addr, `PORT_COLOR_GRAPHICS_OPERATION);
wire wr_ccs = i_io_wr && i_compat_mode
    && hit(i_io_addr, `PORT_COLOR_GRAPHICS_COLOR_SELECT);
// Both strap bits must be up before the extended register listens
wire wr_ext = i_io_wr && i_compat_mode && i_ext_mode_enable
    && hit(i_io_addr, `PORT_EXTENDED_400_LINE_MODE);
wire rd_mono = i_compat_mode && hit(i_io_addr, `PORT_MONO_RASTER_STATUS);
wire rd_color = i_compat_mode && hit(i_io_addr, `PORT_COLOR_RASTER_STATUS);

// Write-only ports never claim a read, so another device may answer
assign o_io_rd_hit = i_io_rd && (rd_mono || rd_color);

////////////////////////////////////////////////////////////////////////////////
// Registers

always @(posedge i_mclk)
begin
    if (i_srst)
    begin
        mono_graphics_page_ctrl <= `RESET_MGP;
        color_graphics_operation <= `RESET_CGO;
        color_graphics_color_select <= `RESET_CCS;
        extended_400_line_mode <= `RESET_EXT;
    end
    else
    begin
        if (wr_mgp)
            mono_graphics_page_ctrl <= {6'h00, i_io_wdata[1:0]};
        if (wr_cgo)
            color_graphics_operation <= {2'h0, i_io_wdata[5:0]};
        if (wr_ccs)
            color_graphics_color_select <= {2'h0, i_io_wdata[5:0]};
        if (wr_ext)
            extended_400_line_mode <= i_io_wdata & 8'h4D;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Status read data, registered one cycle after the strobe

reg [7:0] next_rdata;

always @*
begin
    next_rdata = 8'h00;
    if (rd_mono)
    begin
        next_rdata[`MRS_VSYNC_INACTIVE] = ~i_vsync;
        next_rdata[`MRS_VIDEO_STATUS] = i_mono_video_on;
        next_rdata[`MRS_DISPLAY_INACTIVE] = ~i_display_enable;
    end
    else if (rd_color)
    begin
        next_rdata[`CRS_VSYNC_ACTIVE] = i_vsync;
        next_rdata[`CRS_PEN_SWITCH] = ~i_pen_switch_closed;
        next_rdata[`CRS_PEN_LATCH] = i_pen_latch_set;
        next_rdata[`CRS_DISPLAY_INACTIVE] = ~i_display_enable;
    end
end

always @(posedge i_mclk)
begin
    if (i_srst)
        o_io_rdata <= 8'h00;
    else if (i_io_rd)
        o_io_rdata <= next_rdata;
end

////////////////////////////////////////////////////////////////////////////////
// Mode and colour outputs

reg cgo_blink, cgo_bw, cgo_video, cgo_g320, cgo_c80;
reg cs_i, cs_r, cs_g, cs_b;
reg [3:0] next_bg, next_fg;
reg [2:0] next_border;

always @*
begin
    cgo_blink = color_graphics_operation[`CGO_BLINK_ENABLE];
    cgo_bw = color_graphics_operation[`CGO_BW_GRAPHICS_640];
    cgo_video = color_graphics_operation[`CGO_VIDEO_ENABLE];
    cgo_g320 = color_graphics_operation[`CGO_GRAPHICS_320];
    cgo_c80 = color_graphics_operation[`CGO_COLUMNS_80];
    cs_i = color_graphics_color_select[`CCS_INTENSITY];
    cs_r = color_graphics_color_select[`CCS_RED];
    cs_g = color_graphics_color_select[`CCS_GREEN];
    cs_b = color_graphics_color_select[`CCS_BLUE];
    next_border = 3'h0;
    next_bg = 4'h0;
    next_fg = 4'hF;
    if (cgo_bw)
    begin
        // 640 mode: the select bits paint the foreground on black
        next_fg = {cs_i, cs_r, cs_g, cs_b};
    end
    else if (cgo_g320)
    begin
        next_bg = {cs_i, cs_r, cs_g, cs_b};
        next_border = {cs_r, cs_g, cs_b};
    end
    else
    begin
        next_border = {cs_r, cs_g, cs_b};
    end
end

always @(posedge i_mclk)
begin
    if (i_srst)
    begin
        o_upper_page_access <= 1'b0;
        o_graphics_enable <= 1'b0;
        o_blink_enable <= 1'b0;
        o_bw_graphics_640 <= 1'b0;
        o_video_enable <= 1'b0;
        o_graphics_320 <= 1'b0;
        o_text_80_columns <= 1'b0;
        o_color_set_cyan <= 1'b0;
        o_alt_color_set <= 1'b0;
        o_intensity <= 1'b0;
        o_border_rgb <= 3'h0;
        o_background_irgb <= 4'h0;
        o_foreground_irgb <= 4'hF;
        o_underline_white <= 1'b0;
        o_page_bc00 <= 1'b0;
        o_font_plane3 <= 1'b0;
        o_lines_400 <= 1'b0;
    end
    else
    begin
        o_upper_page_access <= i_compat_mode
            && mono_graphics_page_ctrl[`MGP_UPPER_PAGE];
        // Override low forces alpha regardless of the graphics bit
        o_graphics_enable <= i_compat_mode && i_mode_override
            && mono_graphics_page_ctrl[`MGP_ENABLE_GRAPHICS];
        o_blink_enable <= i_compat_mode && cgo_blink;
        o_bw_graphics_640 <= i_compat_mode && cgo_bw;
        o_video_enable <= i_compat_mode && cgo_video;
        o_graphics_320 <= i_compat_mode && cgo_g320;
        o_text_80_columns <= i_compat_mode && cgo_c80;
        o_color_set_cyan <= color_graphics_color_select[`CCS_COLOR_SET];
        o_alt_color_set <= color_graphics_color_select[`CCS_ALT_SET];
        o_intensity <= cs_i && !cgo_bw;
        o_border_rgb <= next_border;
        o_background_irgb <= next_bg;
        o_foreground_irgb <= next_fg;
        o_underline_white <= extended_400_line_mode[`EXT_UNDERLINE_WHITE];
        o_page_bc00 <= extended_400_line_mode[`EXT_PAGE_SELECT];
        o_font_plane3 <= extended_400_line_mode[`EXT_CHAR_SET];
        o_lines_400 <= extended_400_line_mode[`EXT_LINES_400];
    end
end

endmodule // legacy_display_compat_regs

// >>> logic/legacy_display_compat_defines.vh
// Port addresses, field positions and reset values of the legacy compatibility registers
`ifndef LEGACY_DISPLAY_COMPAT_DEFINES_VH
`define LEGACY_DISPLAY_COMPAT_DEFINES_VH

`define PORT_MONO_RASTER_STATUS 10'h3BA
`define PORT_MONO_GRAPHICS_PAGE_CTRL 10'h3BF
`define PORT_COLOR_GRAPHICS_OPERATION 10'h3D8
`define PORT_COLOR_GRAPHICS_COLOR_SELECT 10'h3D9
`define PORT_COLOR_RASTER_STATUS 10'h3DA
`define PORT_EXTENDED_400_LINE_MODE 10'h3DE

// mono_graphics_page_ctrl
`define MGP_ENABLE_GRAPHICS 0
`define MGP_UPPER_PAGE 1
// color_graphics_operation
`define CGO_COLUMNS_80 0
`define CGO_GRAPHICS_320 1
`define CGO_VIDEO_ENABLE 3
`define CGO_BW_GRAPHICS_640 4
`define CGO_BLINK_ENABLE 5
// color_graphics_color_select
`define CCS_BLUE 0
`define CCS_GREEN 1
`define CCS_RED 2
`define CCS_INTENSITY 3
`define CCS_ALT_SET 4
`define CCS_COLOR_SET 5
// extended_400_line_mode
`define EXT_LINES_400 0
`define EXT_CHAR_SET 2
`define EXT_PAGE_SELECT 3
`define EXT_UNDERLINE_WHITE 6
// mono_raster_status
`define MRS_DISPLAY_INACTIVE 0
`define MRS_VIDEO_STATUS 3
`define MRS_VSYNC_INACTIVE 7
// color_raster_status
`define CRS_DISPLAY_INACTIVE 0
`define CRS_PEN_LATCH 1
`define CRS_PEN_SWITCH 2
`define CRS_VSYNC_ACTIVE 3

`define RESET_MGP 8'h00
`define RESET_CGO 8'h00
`define RESET_CCS 8'h00
`define RESET_EXT 8'h00

`endif

// >>> sim/compat_regs_props.sv
// Concurrent checks on the compatibility register bank ports
`timescale 1ns/100ps
module compat_regs_props
(
    input wire i_mclk,
    input wire i_srst,
    input wire [9:0] i_io_addr,
    input wire i_io_wr,
    input wire i_io_rd,
    input wire [7:0] i_io_wdata,
    input wire [7:0] o_io_rdata,
    input wire o_io_rd_hit,
    input wire i_compat_mode,
    input wire i_ext_mode_enable,
    input wire i_vsync,
    input wire i_display_enable,
    input wire i_mono_video_on,
    input wire i_pen_switch_closed,
    input wire i_pen_latch_set,
    input wire o_video_enable,
    input wire o_lines_400
);
    wire ext_take = i_io_wr && i_compat_mode && i_ext_mode_enable && i_io_addr == 10'h3DE;
    wire op_take = i_io_wr && i_compat_mode && i_io_addr == 10'h3D8;
    default clocking dc @(posedge i_mclk); endclocking
    default disable iff (i_srst);
////////////////////////////////////////////////////////////////////////////////
    video_gate_a: assert property (op_take ##1 i_compat_mode |=>
        o_video_enable == $past(i_io_wdata[3], 2)) else $error("video enable mismatch");
    compat_off_a: assert property (!i_compat_mode |=> !o_video_enable)
        else $error("video on without compat mode");
    ext_gate_a: assert property (!ext_take |-> ##2 $stable(o_lines_400))
        else $error("line mode moved without write");
    ext_load_a: assert property (ext_take |-> ##2
        o_lines_400 == $past(i_io_wdata[0], 2)) else $error("line mode not loaded");
    rd_hit_a: assert property (o_io_rd_hit == (i_io_rd && i_compat_mode
        && (i_io_addr == 10'h3BA || i_io_addr == 10'h3DA))) else $error("read hit wrong");
    color_stat_a: assert property (i_io_rd && i_compat_mode && i_io_addr == 10'h3DA |=>
        o_io_rdata == {4'h0, $past(i_vsync), !$past(i_pen_switch_closed),
        $past(i_pen_latch_set), !$past(i_display_enable)}) else $error("colour status wrong");
    mono_stat_a: assert property (i_io_rd && i_compat_mode && i_io_addr == 10'h3BA |=>
        o_io_rdata == {!$past(i_vsync), 3'h0, $past(i_mono_video_on), 2'h0,
        !$past(i_display_enable)}) else $error("mono status wrong");
    ext_reset_a: assert property ($fell(i_srst) |-> !o_lines_400)
        else $error("line mode set after reset");
    cover property (ext_take);
    cover property (op_take);
    cover property (o_io_rd_hit);
endmodule // compat_regs_props

bind legacy_display_compat_regs compat_regs_props u_props
(
    .i_mclk(i_mclk), .i_srst(i_srst), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr),
    .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
    .o_io_rd_hit(o_io_rd_hit), .i_compat_mode(i_compat_mode),
    .i_ext_mode_enable(i_ext_mode_enable), .i_vsync(i_vsync),
    .i_display_enable(i_display_enable), .i_mono_video_on(i_mono_video_on),
    .i_pen_switch_closed(i_pen_switch_closed), .i_pen_latch_set(i_pen_latch_set),
    .o_video_enable(o_video_enable), .o_lines_400(o_lines_400)
);

// >>> sim/io_host_model.sv
// Host processor model issuing single-byte I/O port cycles
`timescale 1ns/100ps
module io_host_model
(
    input wire i_mclk,
    input wire [7:0] i_io_rdata,
    output reg [9:0] o_io_addr,
    output reg o_io_wr,
    output reg o_io_rd,
    output reg [7:0] o_io_wdata
);
    initial
    begin
        o_io_addr = 10'h000;
        o_io_wr = 1'b0;
        o_io_rd = 1'b0;
        o_io_wdata = 8'h00;
    end
    task io_write(input [9:0] a, input [7:0] d);
    begin
        @(negedge i_mclk);
        o_io_addr = a;
        o_io_wdata = d;
        o_io_wr = 1'b1;
        @(negedge i_mclk);
        o_io_wr = 1'b0;
        // Released data bus must not keep the old byte
        o_io_wdata = ~d;
    end
    endtask
    task io_read(input [9:0] a, output [7:0] d);
    begin
        @(negedge i_mclk);
        o_io_addr = a;
        o_io_rd = 1'b1;
        @(negedge i_mclk);
        o_io_rd = 1'b0;
        d = i_io_rdata;
    end
    endtask
endmodule // io_host_model

// >>> sim/legacy_display_compat_regs_tb_top.sv
// Self-checking bench for the compatibility register bank
`timescale 1ns/100ps
module legacy_display_compat_regs_tb_top;
    reg mclk = 0, srst = 1, compat = 1, ext_en = 0, ovr = 0;
    reg vs = 0, de = 0, von = 0, sw = 0, lat = 0;
    wire [9:0] addr;
    wire wr, rd, up, ge, bl, bw, ve, g320, c80, cy, alt, inten, ul, pg, fp, l400;
    wire [7:0] wdata, rdata;
    wire [2:0] brd;
    wire [3:0] bg, fg;
    integer err_total = 0, samples_checked = 0, k;
    reg [7:0] d;
    initial forever #5 mclk = ~mclk;
    io_host_model i_host (.i_mclk(mclk), .i_io_rdata(rdata), .o_io_addr(addr),
        .o_io_wr(wr), .o_io_rd(rd), .o_io_wdata(wdata));
    legacy_display_compat_regs i_dut (.i_mclk(mclk), .i_srst(srst), .i_io_addr(addr),
        .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wdata), .o_io_rdata(rdata), .o_io_rd_hit(),
        .i_compat_mode(compat), .i_ext_mode_enable(ext_en), .i_mode_override(ovr),
        .i_vsync(vs), .i_display_enable(de), .i_mono_video_on(von),
        .i_pen_switch_closed(sw), .i_pen_latch_set(lat), .o_upper_page_access(up),
        .o_graphics_enable(ge), .o_blink_enable(bl), .o_bw_graphics_640(bw),
        .o_video_enable(ve), .o_graphics_320(g320), .o_text_80_columns(c80),
        .o_color_set_cyan(cy), .o_alt_color_set(alt), .o_intensity(inten),
        .o_border_rgb(brd), .o_background_irgb(bg), .o_foreground_irgb(fg),
        .o_underline_white(ul), .o_page_bc00(pg), .o_font_plane3(fp), .o_lines_400(l400));
////////////////////////////////////////////////////////////////////////////////
    task check(input string n, input [7:0] seen, input [7:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("ERROR %0s expected %h seen %h", n, exp, seen);
        end
    end
    endtask
    // Mode outputs land one cycle after the register
    task wr_reg(input [9:0] a, input [7:0] v);
    begin
        i_host.io_write(a, v);
        @(negedge mclk);
    end
    endtask
    task report_and_stop;
    begin
        if (err_total == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
////////////////////////////////////////////////////////////////////////////////
    task t_operation;
    begin
        for (k = 0; k < 2; k = k + 1)
        begin
            d = k ? 8'h06 : 8'h39;
            wr_reg(10'h3D8, d);
            check("blink", bl, d[5]);
            check("bw640", bw, d[4]);
            check("video", ve, d[3]);
            check("gfx320", g320, d[1]);
            check("col80", c80, d[0]);
        end
    end
    endtask
    task t_color;
    begin
        wr_reg(10'h3D8, 8'h02);
        wr_reg(10'h3D9, 8'h2D);
        check("cyan", cy, 1);
        check("alt", alt, 0);
        check("border", brd, 3'h5);
        check("backgnd", bg, 4'hD);
        check("intens", inten, 1);
        wr_reg(10'h3D9, 8'h12);
        check("alt", alt, 1);
        check("backgnd", bg, 4'h2);
        wr_reg(10'h3D8, 8'h10);
        wr_reg(10'h3D9, 8'h0B);
        check("foregnd", fg, 4'hB);
        check("intens640", inten, 0);
        check("border", brd, 3'h0);
    end
    endtask
    task t_status;
    begin
        for (k = 0; k < 2; k = k + 1)
        begin
            vs = k;
            de = !k;
            von = k;
            sw = k;
            lat = !k;
            i_host.io_read(10'h3DA, d);
            check("cstat", d, {4'h0, vs, !sw, lat, !de});
            i_host.io_read(10'h3BA, d);
            check("mstat", d, {!vs, 3'h0, von, 2'h0, !de});
        end
        i_host.io_read(10'h3D8, d);
        check("wo_read", d, 8'h00);
    end
    endtask
    task t_ext;
    begin
        wr_reg(10'h3DE, 8'hFF);
        check("lines400", l400, 0);
        ext_en = 1;
        wr_reg(10'h3DE, 8'hFF);
        check("underline", ul, 1);
        check("page", pg, 1);
        check("font", fp, 1);
        check("lines400", l400, 1);
        srst = 1;
        @(negedge mclk);
        srst = 0;
        check("ext_rst", {ul, pg, fp, l400}, 0);
    end
    endtask
    task t_page;
    begin
        wr_reg(10'h3BF, 8'h03);
        check("upper", up, 1);
        check("gfx_en", ge, 0);
        ovr = 1;
        wr_reg(10'h3BF, 8'h01);
        check("upper", up, 0);
        check("gfx_en", ge, 1);
        compat = 0;
        @(negedge mclk);
        check("gfx_off", ge, 0);
        i_host.io_read(10'h3DA, d);
        check("off_read", d, 8'h00);
    end
    endtask
    initial
    begin
        repeat (20) @(negedge mclk);
        srst = 0;
        check("ext_init", {ul, pg, fp, l400}, 0);
        t_operation;
        t_color;
        t_status;
        t_ext;
        t_page;
        report_and_stop;
    end
    initial
    begin
        #500000;
        err_total = err_total + 1;
        report_and_stop;
    end
endmodule // legacy_display_compat_regs_tb_top
